// [hdl/pop_sequencer.sv]
// Output driver pop sequencer: power-up delay, gain ramp, speaker wait, DAC ordering
//
// Behaviour
// - Ordering bit 0: DAC turns off on power-down without waiting for the headphone gain ramp-down or either amplifier.
// - Ordering bit 1: on power-down the DAC turns off only after both amplifiers are fully off; otherwise it follows dac_power_req.
// - Four-bit power-on delay select, 0 up to 6.1 s, reset code 0111.
// - Two-bit ramp step select 0, 0.98, 1.95, 3.9 ms; reset code 11.
// - All delays count oscillator cycles and scale with its real frequency.
// - Common-mode source bit 0 selects supply divider; software never writes 1.
// - Three-bit speaker wait select 0 to 30.5 ms; reset code 000.
`timescale 1ns/1ps
module pop_sequencer
  import pop_seq_pkg::*;
#(
  parameter int unsigned OSC_KHZ = OSC_NOMINAL_KHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Power control from the rest of the device
  input wire logic osc_pin,
  input wire logic dac_power_req,
  input wire logic hp_power_req,
  input wire logic spk_power_req,
  input wire logic shutdown_req,
  input wire logic [GAIN_W-1:0] target_gain,
  // Driver controls
  output logic hp_amp_on_q,
  output logic spk_amp_on_q,
  output logic dac_on_q,
  output logic [GAIN_W-1:0] hp_gain_q,
  output logic gain_applied_q,
  output logic cm_src_q
);

  // ----------------------------------------------------------------
  // Duration conversion
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] ns_to_ticks(input longint unsigned ns);
    longint unsigned ticks;
    ticks = ns * OSC_KHZ / 64'd1000000;
    return ticks[CNT_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  hp_pop_cfg_t hp_cfg_q;
  spk_wait_cfg_t spk_cfg_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hp_cfg_q <= hp_pop_cfg_t'(HP_POP_CFG_RST);
      spk_cfg_q <= spk_wait_cfg_t'(SPK_WAIT_CFG_RST);
    end else if (reg_wr) begin
      if (reg_addr == HP_POP_CFG_OFS) begin
        hp_cfg_q <= hp_pop_cfg_t'(reg_wdata);
      end
      if (reg_addr == SPK_WAIT_CFG_OFS) begin
        spk_cfg_q <= spk_wait_cfg_t'(reg_wdata);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_addr == HP_POP_CFG_OFS) begin
      reg_rdata_q <= hp_cfg_q;
    end else if (reg_addr == SPK_WAIT_CFG_OFS) begin
      reg_rdata_q <= spk_cfg_q;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // Reserved value 1 is passed through untouched; only 0 has a defined meaning
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cm_src_q <= 1'b0;
    end else begin
      cm_src_q <= hp_cfg_q.cm_src;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  logic [2:0] osc_sync_q;
  logic osc_lvl_q;
  logic osc_tick;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_sync_q <= 3'h0;
      osc_lvl_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], osc_pin};
      if (osc_sync_q[1] == osc_sync_q[2]) begin
        osc_lvl_q <= osc_sync_q[2];
      end
    end
  end

  // Durations track the real oscillator since every count step is one of its edges
  assign osc_tick = (osc_sync_q[1] == osc_sync_q[2]) && osc_sync_q[2] && !osc_lvl_q;

  // ----------------------------------------------------------------
  // Shutdown latch
  // ----------------------------------------------------------------
  logic shutdown_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      shutdown_q <= 1'b0;
    end else if (shutdown_req) begin
      shutdown_q <= 1'b1;
    end else if (!dac_power_req && !hp_power_req && !spk_power_req) begin
      shutdown_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Headphone sequence
  // ----------------------------------------------------------------
  hp_state_t hp_state_q;
  logic hp_go;
  logic hp_load;
  logic [CNT_W-1:0] hp_load_val;
  logic hp_done;
  logic [CNT_W-1:0] ramp_ticks;

  assign hp_go = hp_power_req && !shutdown_q;
  assign ramp_ticks = ns_to_ticks(RAMP_STEP_NS[hp_cfg_q.ramp_sel]);

  always_comb begin
    hp_load = 1'b0;
    hp_load_val = ramp_ticks;
    case (hp_state_q)
      HP_OFF: begin
        hp_load = hp_go;
        hp_load_val = ns_to_ticks(ON_DELAY_NS[hp_cfg_q.on_delay_sel]);
      end
      HP_DELAY, HP_RAMP, HP_RAMP_DOWN: begin
        hp_load = hp_done;
      end
      HP_ON: begin
        hp_load = !hp_go || hp_gain_q != target_gain;
      end
      default: begin
        hp_load = 1'b0;
      end
    endcase
  end

  osc_timer u_hp_timer (
    .core_clk(core_clk),
    .reset(reset),
    .load(hp_load),
    .load_val(hp_load_val),
    .osc_tick(osc_tick),
    .done(hp_done)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hp_state_q <= HP_OFF;
      hp_amp_on_q <= 1'b0;
      hp_gain_q <= '0;
    end else begin
      case (hp_state_q)
        HP_OFF: begin
          if (hp_go) begin
            hp_state_q <= HP_DELAY;
          end
        end
        HP_DELAY: begin
          if (!hp_go) begin
            hp_state_q <= HP_OFF;
          end else if (hp_done) begin
            hp_amp_on_q <= 1'b1;
            hp_state_q <= HP_RAMP;
          end
        end
        HP_RAMP: begin
          if (!hp_go) begin
            hp_state_q <= HP_RAMP_DOWN;
          end else if (hp_gain_q == target_gain) begin
            hp_state_q <= HP_ON;
          end else if (hp_done) begin
            // One gain step per ramp interval, in either direction
            if (hp_gain_q < target_gain) begin
              hp_gain_q <= hp_gain_q + 1'b1;
            end else begin
              hp_gain_q <= hp_gain_q - 1'b1;
            end
          end
        end
        HP_ON: begin
          if (!hp_go) begin
            hp_state_q <= HP_RAMP_DOWN;
          end else if (hp_gain_q != target_gain) begin
            hp_state_q <= HP_RAMP;
          end
        end
        HP_RAMP_DOWN: begin
          if (hp_gain_q == '0) begin
            hp_amp_on_q <= 1'b0;
            hp_state_q <= HP_OFF;
          end else if (hp_done) begin
            hp_gain_q <= hp_gain_q - 1'b1;
          end
        end
        default: begin
          hp_state_q <= HP_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gain_applied_q <= 1'b0;
    end else begin
      gain_applied_q <= (hp_state_q == HP_ON) && (hp_gain_q == target_gain);
    end
  end

  // ----------------------------------------------------------------
  // Speaker sequence
  // ----------------------------------------------------------------
  spk_state_t spk_state_q;
  logic spk_go;
  logic spk_done;

  assign spk_go = spk_power_req && !shutdown_q;

  osc_timer u_spk_timer (
    .core_clk(core_clk),
    .reset(reset),
    .load(spk_state_q == SPK_OFF && spk_go),
    .load_val(ns_to_ticks(SPK_WAIT_NS[spk_cfg_q.wait_sel])),
    .osc_tick(osc_tick),
    .done(spk_done)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      spk_state_q <= SPK_OFF;
      spk_amp_on_q <= 1'b0;
    end else begin
      case (spk_state_q)
        SPK_OFF: begin
          if (spk_go) begin
            spk_state_q <= SPK_WAIT;
          end
        end
        SPK_WAIT: begin
          if (!spk_go) begin
            spk_state_q <= SPK_OFF;
          end else if (spk_done) begin
            spk_amp_on_q <= 1'b1;
            spk_state_q <= SPK_ON;
          end
        end
        SPK_ON: begin
          if (!spk_go) begin
            spk_amp_on_q <= 1'b0;
            spk_state_q <= SPK_OFF;
          end
        end
        default: begin
          spk_state_q <= SPK_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // DAC ordering
  // ----------------------------------------------------------------
  logic amps_all_off;

  assign amps_all_off = !hp_amp_on_q && !spk_amp_on_q &&
                        hp_state_q == HP_OFF && spk_state_q == SPK_OFF;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dac_on_q <= 1'b0;
    end else if (shutdown_q && !hp_cfg_q.dac_after_amps) begin
      dac_on_q <= 1'b0;
    end else if (shutdown_q) begin
      // Holding the DAC until the amplifiers are quiet trades power for less pop
      dac_on_q <= dac_on_q && !amps_all_off;
    end else begin
      dac_on_q <= dac_power_req;
    end
  end

endmodule

// [hdl/pop_seq_pkg.sv]
// Constants, register layouts and types for the output driver pop sequencer
package pop_seq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HP_POP_CFG_OFS = 8'h21;
  localparam logic [7:0] SPK_WAIT_CFG_OFS = 8'h22;
  localparam logic [7:0] HP_POP_CFG_RST = 8'h3e;
  localparam logic [7:0] SPK_WAIT_CFG_RST = 8'h00;

  typedef struct packed {
    logic dac_after_amps;
    logic [3:0] on_delay_sel;
    logic [1:0] ramp_sel;
    logic cm_src;
  } hp_pop_cfg_t;

  typedef struct packed {
    logic rsvd_hi;
    logic [2:0] wait_sel;
    logic [3:0] rsvd_lo;
  } spk_wait_cfg_t;

  // ----------------------------------------------------------------
  // Timing, in nanoseconds of the nominal oscillator
  // ----------------------------------------------------------------
  localparam int unsigned OSC_NOMINAL_KHZ = 8200;
  localparam int CNT_W = 27;
  localparam int GAIN_W = 4;

  localparam longint unsigned ON_DELAY_NS [16] = '{
    64'd0, 64'd15300, 64'd153000, 64'd1530000,
    64'd15300000, 64'd76200000, 64'd153000000, 64'd304000000,
    64'd610000000, 64'd1220000000, 64'd3040000000, 64'd6100000000,
    64'd6100000000, 64'd6100000000, 64'd6100000000, 64'd6100000000};

  localparam longint unsigned RAMP_STEP_NS [4] = '{
    64'd0, 64'd980000, 64'd1950000, 64'd3900000};

  localparam longint unsigned SPK_WAIT_NS [8] = '{
    64'd0, 64'd3040000, 64'd7620000, 64'd12200000,
    64'd15300000, 64'd19800000, 64'd24400000, 64'd30500000};

  typedef enum logic [2:0] {
    HP_OFF, HP_DELAY, HP_RAMP, HP_ON, HP_RAMP_DOWN
  } hp_state_t;

  typedef enum logic [1:0] {
    SPK_OFF, SPK_WAIT, SPK_ON
  } spk_state_t;

  typedef struct packed {
    logic hp_amp_on;
    logic spk_amp_on;
    logic dac_on;
    logic gain_applied;
  } drv_status_t;

endpackage

// [hdl/osc_timer.sv]
// Down counter paced by oscillator ticks
`timescale 1ns/1ps
module osc_timer
  import pop_seq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  input wire logic osc_tick,
  // Status
  output logic done
);

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (osc_tick && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Depends on the count only, so a caller may derive load from done without a loop
  assign done = (cnt_q == '0);

endmodule

// [verification/pop_sequencer_assertions.sv]
// Port-level checks for the pop sequencer
`timescale 1ns/1ps
module pop_sequencer_assertions
  import pop_seq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  // Requests
  input wire logic dac_power_req,
  input wire logic hp_power_req,
  input wire logic spk_power_req,
  input wire logic shutdown_req,
  input wire logic [GAIN_W-1:0] target_gain,
  // Driver controls
  input wire logic hp_amp_on_q,
  input wire logic spk_amp_on_q,
  input wire logic dac_on_q,
  input wire logic [GAIN_W-1:0] hp_gain_q,
  input wire logic gain_applied_q
);
  logic ord_q;
  logic sd_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Shadows of the ordering bit and the latched power-down
  always_ff @(posedge core_clk) begin
    if (reset || (reg_wr && reg_addr == HP_POP_CFG_OFS)) begin
      ord_q <= reset ? 1'b0 : reg_wdata[7];
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sd_q <= 1'b0;
    end else if (shutdown_req || !(dac_power_req || hp_power_req || spk_power_req)) begin
      sd_q <= shutdown_req;
    end
  end
  dac_together_a: assert property (shutdown_req && !ord_q |-> ##[1:2] !dac_on_q)
    else $error("dac stayed on after power-down");
  dac_last_a: assert property ($fell(dac_on_q) && $past(ord_q && dac_power_req)
    |-> $past(!hp_amp_on_q && !spk_amp_on_q)) else $error("dac off before amplifiers");
  dac_follow_a: assert property ($past(!sd_q && !shutdown_req)
    |-> dac_on_q == $past(dac_power_req)) else $error("dac does not follow request");
  gain_step_a: assert property (hp_gain_q > $past(hp_gain_q)
    |-> hp_gain_q == $past(hp_gain_q) + 4'h1) else $error("gain jumped");
  gain_off_a: assert property (hp_gain_q != 4'h0 |-> hp_amp_on_q)
    else $error("gain while amplifier off");
  gain_done_a: assert property ($rose(gain_applied_q)
    |-> $past(hp_gain_q) == $past(target_gain)) else $error("applied flag early");
  hp_cause_a: assert property ($rose(hp_amp_on_q) |-> $past(hp_power_req))
    else $error("headphone on without request");
  spk_drop_a: assert property (!spk_power_req |=> !spk_amp_on_q)
    else $error("speaker stayed on");
endmodule

bind pop_sequencer pop_sequencer_assertions u_chk (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .dac_power_req(dac_power_req), .hp_power_req(hp_power_req),
  .spk_power_req(spk_power_req), .shutdown_req(shutdown_req), .target_gain(target_gain),
  .hp_amp_on_q(hp_amp_on_q), .spk_amp_on_q(spk_amp_on_q), .dac_on_q(dac_on_q),
  .hp_gain_q(hp_gain_q), .gain_applied_q(gain_applied_q));

// [verification/pop_sequencer_tb.sv]
// Self-checking bench for the pop sequencer
`timescale 1ns/1ps
module pop_sequencer_tb;
  import pop_seq_pkg::*;
  logic core_clk = 0;
  logic reset = 1;
  logic [7:0] reg_addr = 0;
  logic reg_wr = 0;
  logic [7:0] reg_wdata = 0;
  logic [7:0] reg_rdata_q;
  logic osc_pin = 0;
  logic dac_power_req = 0;
  logic hp_power_req = 0;
  logic spk_power_req = 0;
  logic shutdown_req = 0;
  logic [GAIN_W-1:0] target_gain = 4'h2;
  logic [GAIN_W-1:0] hp_gain_q;
  logic hp_amp_on_q, spk_amp_on_q, dac_on_q, gain_applied_q, cm_src_q;
  logic [1:0] osc_div = 0;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int tk [3] = '{0, 304, 6100};
  // Only defined delay codes; 1100 to 1111 are never written
  logic [3:0] code [3] = '{4'h0, 4'h7, 4'hb};
  // Common-mode bit and reserved speaker bits are always written as zero
  logic [23:0] rows [4] = '{24'h21a4a4, 24'h221010, 24'h305500, 24'h227070};

  pop_sequencer #(.OSC_KHZ(1)) uut (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .osc_pin(osc_pin), .dac_power_req(dac_power_req), .hp_power_req(hp_power_req),
    .spk_power_req(spk_power_req), .shutdown_req(shutdown_req), .target_gain(target_gain),
    .hp_amp_on_q(hp_amp_on_q), .spk_amp_on_q(spk_amp_on_q), .dac_on_q(dac_on_q),
    .hp_gain_q(hp_gain_q), .gain_applied_q(gain_applied_q), .cm_src_q(cm_src_q));

  always #20 core_clk = ~core_clk;
  // Oscillator at a quarter of the core rate keeps a 6.1 s code within the run
  always @(posedge core_clk) begin
    osc_div <= osc_div + 2'h1;
    osc_pin <= osc_div[1];
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(int got, int lo, int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 chk(reg_rdata_q, exp);
  endtask
  // Cycles until: 0 headphone on, 1 gain applied, 2 speaker on, 3 both off
  task automatic meas(int sel);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (!(sel == 0 ? hp_amp_on_q === 1 : sel == 1 ? gain_applied_q === 1 :
      sel == 2 ? spk_amp_on_q === 1 : hp_amp_on_q === 0 && spk_amp_on_q === 0) && n < 30000);
  endtask
  task automatic set_req(logic v);
    @(posedge core_clk);
    dac_power_req <= v;
    hp_power_req <= v;
    spk_power_req <= v;
  endtask
  task automatic pulse_sd();
    @(posedge core_clk);
    shutdown_req <= 1;
    @(posedge core_clk);
    shutdown_req <= 0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rst_chk();
    reset <= 1;
    repeat (5) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    #1 chk({hp_gain_q, hp_amp_on_q, spk_amp_on_q, dac_on_q, gain_applied_q}, 8'h00);
    rd(HP_POP_CFG_OFS, 8'h3e);
    rd(SPK_WAIT_CFG_OFS, 8'h00);
  endtask

  initial begin
    rst_chk();
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk({7'h0, cm_src_q}, 8'h00);
    foreach (code[i]) begin
      wr(HP_POP_CFG_OFS, {1'b0, code[i], 3'h0});
      @(posedge core_clk);
      hp_power_req <= 1;
      meas(0);
      chk_rng(n, 4 * tk[i] - 4, 4 * tk[i] + 16);
      @(posedge core_clk);
      hp_power_req <= 0;
      meas(3);
    end
    // Slowest ramp step is three ticks, twelve core cycles
    wr(HP_POP_CFG_OFS, 8'h06);
    @(posedge core_clk);
    hp_power_req <= 1;
    meas(0);
    meas(1);
    chk_rng(n, 8, 40);
    chk({4'h0, hp_gain_q}, 8'h02);
    @(posedge core_clk);
    spk_power_req <= 1;
    meas(2);
    chk_rng(n, 116, 136);
    @(posedge core_clk);
    dac_power_req <= 1;
    repeat (3) @(posedge core_clk);
    #1 chk({7'h0, dac_on_q}, 8'h01);
    wr(HP_POP_CFG_OFS, 8'h86);
    pulse_sd();
    #1 chk({7'h0, dac_on_q}, 8'h01);
    meas(3);
    repeat (3) @(posedge core_clk);
    #1 chk({7'h0, dac_on_q}, 8'h00);
    set_req(0);
    wr(HP_POP_CFG_OFS, 8'h00);
    set_req(1);
    meas(2);
    pulse_sd();
    #1 chk({7'h0, dac_on_q}, 8'h00);
    set_req(0);
    rst_chk();
    finish_test();
  end
endmodule
